// ===== common/counter4_map.vh
`ifndef COUNTER4_MAP_VH
`define COUNTER4_MAP_VH

// register byte offsets on the apb slave
`define CNT_CTRL_OFS 8'h00
`define CNT_PRESET_OFS 8'h04
`define CNT_STATUS_OFS 8'h08
`define CNT_WRAPS_OFS 8'h0c
`define CNT_CAPTURE_OFS 8'h10

// control register fields, both are write-only strobes
`define CNT_CTRL_LOAD_BIT 0
`define CNT_CTRL_CAPTURE_BIT 1

// status register fields
`define CNT_STAT_VALUE_LSB 0
`define CNT_STAT_VALUE_MSB 3
`define CNT_STAT_TC_BIT 4
`define CNT_STAT_WRAP_BIT 5
`define CNT_STAT_LOADED_BIT 6

// counter geometry and reset values
`define CNT_WIDTH 4
`define CNT_TOP_VALUE 4'hf
`define CNT_ZERO_VALUE 4'h0
`define CNT_STEP 4'h1
`define CNT_PRESET_RST 4'h0
`define CNT_WRAPS_WIDTH 16
`define CNT_WRAPS_RST 16'h0000
`define CNT_WRAPS_STEP 16'h0001

`endif

// ===== hdl/counter4_core.v
`timescale 1ns/100ps
`default_nettype none

`include "counter4_map.vh"

module counter4_core (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire async_clear_n_i,
    input wire load_i,
    input wire [`CNT_WIDTH-1:0] preset_i,
    input wire count_enable_parallel_i,
    input wire count_enable_trickle_i,
    output reg [`CNT_WIDTH-1:0] count_value_o,
    output wire terminal_count_o,
    output wire wrap_o
);

    wire clear_n;
    wire count_en;
    wire at_top;
    reg [`CNT_WIDTH-1:0] count_value_d;

    // the pin clear acts like the system reset: no clock needed
    assign clear_n = rst_n_i & async_clear_n_i;
    assign count_en = count_enable_parallel_i & count_enable_trickle_i;
    assign at_top = (count_value_o == `CNT_TOP_VALUE);

    // decoded straight from state and trickle enable, may glitch downstream
    assign terminal_count_o = count_enable_trickle_i & at_top;
    assign wrap_o = clear_n & ~load_i & count_en & at_top;

    // load beats count, count beats hold; clear handled by the flop reset
    always @* begin
        count_value_d = count_value_o;
        if (load_i) begin
            count_value_d = preset_i;
        end else if (count_en) begin
            // plain 4-bit add wraps 15 to 0 by itself
            count_value_d = count_value_o + `CNT_STEP;
        end
    end

    // load and count enables reach the count only here, on the rising edge; clear acts at once
    always @(posedge ref_clk_i or negedge clear_n) begin
        if (!clear_n) begin
            count_value_o <= `CNT_ZERO_VALUE;
        end else begin
            count_value_o <= count_value_d;
        end
    end

endmodule // counter4_core

`default_nettype wire

// ===== hdl/counter4_top.v
// How it works
// - four-bit state steps through sixteen binary values while counting.
// - counting from fifteen wraps the value to zero on the next edge.
// - count value changes only on rising clock edges, except the clear.
// - priority is clear, then load, then count, else hold.
// - low clear forces count to zero at once, overriding everything.
// - low load enable copies preset inputs at next edge, ignoring count enables.
// - with clear and load inactive, count up only when both enables high.
// - either count enable low leaves the count unchanged.
// - load and count enables are sampled only at the rising edge.
// - terminal count is trickle enable and state fifteen, combinational.
`timescale 1ns/100ps
`default_nettype none

`include "counter4_map.vh"

module counter4_top (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire async_clear_n_i,
    input wire load_enable_n_i,
    input wire count_enable_parallel_i,
    input wire count_enable_trickle_i,
    input wire [`CNT_WIDTH-1:0] preset_inputs_i,
    output wire [`CNT_WIDTH-1:0] count_value_o,
    output wire terminal_count_o,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o
);

    wire setup_phase;
    wire access_phase;
    wire wr_access;
    reg addr_hit;
    reg [31:0] rd_mux;
    wire wr_ctrl;
    wire wr_preset;
    wire wr_status;
    wire wr_wraps;
    wire pin_load;
    wire core_load;
    wire [`CNT_WIDTH-1:0] core_preset;
    wire wrap_evt;

    reg sw_load_q;
    wire sw_load_d;
    reg [`CNT_WIDTH-1:0] sw_preset_q;
    reg wrap_seen_q;
    reg wrap_seen_d;
    reg loaded_seen_q;
    reg loaded_seen_d;
    reg [`CNT_WRAPS_WIDTH-1:0] wraps_q;
    reg [`CNT_WRAPS_WIDTH-1:0] wraps_d;
    reg [`CNT_WIDTH-1:0] capture_q;

    // apb: zero wait states, error on unmapped address
    assign setup_phase = psel_i & ~penable_i;
    assign access_phase = psel_i & penable_i;
    assign pready_o = 1'b1;
    assign pslverr_o = access_phase & ~addr_hit;
    assign wr_access = access_phase & pwrite_i & addr_hit;

    assign wr_ctrl = wr_access & (paddr_i == `CNT_CTRL_OFS);
    assign wr_preset = wr_access & (paddr_i == `CNT_PRESET_OFS);
    assign wr_status = wr_access & (paddr_i == `CNT_STATUS_OFS);
    assign wr_wraps = wr_access & (paddr_i == `CNT_WRAPS_OFS);

    always @* begin
        addr_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr_i)
            `CNT_CTRL_OFS: begin
                rd_mux = 32'h00000000;
            end
            `CNT_PRESET_OFS: begin
                rd_mux[`CNT_WIDTH-1:0] = sw_preset_q;
            end
            `CNT_STATUS_OFS: begin
                rd_mux[`CNT_STAT_VALUE_MSB:`CNT_STAT_VALUE_LSB] = count_value_o;
                rd_mux[`CNT_STAT_TC_BIT] = terminal_count_o;
                rd_mux[`CNT_STAT_WRAP_BIT] = wrap_seen_q;
                rd_mux[`CNT_STAT_LOADED_BIT] = loaded_seen_q;
            end
            `CNT_WRAPS_OFS: begin
                rd_mux[`CNT_WRAPS_WIDTH-1:0] = wraps_q;
            end
            `CNT_CAPTURE_OFS: begin
                rd_mux[`CNT_WIDTH-1:0] = capture_q;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // read data is latched in the setup cycle so it leaves a flop
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (setup_phase) begin
            prdata_o <= rd_mux;
        end
    end

    // a software load is registered first, so it lands one edge later than the pin would
    assign sw_load_d = wr_ctrl & pwdata_i[`CNT_CTRL_LOAD_BIT];
    assign pin_load = ~load_enable_n_i;
    assign core_load = pin_load | sw_load_q;
    // the pin wins if both ask for a load in the same cycle
    assign core_preset = pin_load ? preset_inputs_i : sw_preset_q;

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_load_q <= 1'b0;
            sw_preset_q <= `CNT_PRESET_RST;
        end else begin
            sw_load_q <= sw_load_d;
            if (wr_preset) begin
                sw_preset_q <= pwdata_i[`CNT_WIDTH-1:0];
            end
        end
    end

    counter4_core u_core (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_clear_n_i(async_clear_n_i),
        .load_i(core_load),
        .preset_i(core_preset),
        .count_enable_parallel_i(count_enable_parallel_i),
        .count_enable_trickle_i(count_enable_trickle_i),
        .count_value_o(count_value_o),
        .terminal_count_o(terminal_count_o),
        .wrap_o(wrap_evt)
    );

    // sticky flags are write-one-to-clear; a new event in the same cycle wins
    always @* begin
        wrap_seen_d = wrap_seen_q;
        loaded_seen_d = loaded_seen_q;
        if (wr_status & pwdata_i[`CNT_STAT_WRAP_BIT]) begin
            wrap_seen_d = 1'b0;
        end
        if (wr_status & pwdata_i[`CNT_STAT_LOADED_BIT]) begin
            loaded_seen_d = 1'b0;
        end
        if (wrap_evt) begin
            wrap_seen_d = 1'b1;
        end
        if (core_load & async_clear_n_i) begin
            loaded_seen_d = 1'b1;
        end
    end

    // wrap tally: any write clears it, a wrap in the same cycle counts as one
    always @* begin
        if (wr_wraps) begin
            wraps_d = wrap_evt ? `CNT_WRAPS_STEP : `CNT_WRAPS_RST;
        end else if (wrap_evt) begin
            wraps_d = wraps_q + `CNT_WRAPS_STEP;
        end else begin
            wraps_d = wraps_q;
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wrap_seen_q <= 1'b0;
            loaded_seen_q <= 1'b0;
            wraps_q <= `CNT_WRAPS_RST;
            capture_q <= `CNT_ZERO_VALUE;
        end else begin
            wrap_seen_q <= wrap_seen_d;
            loaded_seen_q <= loaded_seen_d;
            wraps_q <= wraps_d;
            // snapshot lets software read a coherent value of a running count
            if (wr_ctrl & pwdata_i[`CNT_CTRL_CAPTURE_BIT]) begin
                capture_q <= count_value_o;
            end
        end
    end

endmodule // counter4_top

`default_nettype wire

// ===== sim/cascade_stage.sv
`timescale 1ns/100ps
`default_nettype none
module cascade_stage (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic carry_i,
    output logic [3:0] upper_o
);
    // carry is only an enable on the shared clock, never a clock of its own
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) upper_o <= 4'h0;
        else if (carry_i) upper_o <= upper_o + 4'h1;
    end
endmodule // cascade_stage
`default_nettype wire

// ===== sim/counter4_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module counter4_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic async_clear_n_i,
    input wire logic load_enable_n_i,
    input wire logic count_enable_parallel_i,
    input wire logic count_enable_trickle_i,
    input wire logic [3:0] preset_inputs_i,
    input wire logic [3:0] count_value_o,
    input wire logic terminal_count_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o
);
    // a software load lands on the second edge after its write; both edges after the write are skipped
    wire logic sw_ld = psel_i && penable_i && pwrite_i && paddr_i == 8'h00 && pwdata_i[0];
    wire logic run = async_clear_n_i && load_enable_n_i && !sw_ld;
    wire logic both = count_enable_parallel_i && count_enable_trickle_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_tc_decode: assert property (terminal_count_o == (count_enable_trickle_i && count_value_o == 4'hf))
        else $error("terminal count wrong");
    a_clear_zero: assert property (!async_clear_n_i |-> count_value_o == 4'h0 && !terminal_count_o)
        else $error("clear did not zero");
    a_load_copy: assert property (async_clear_n_i && !load_enable_n_i |=>
        !async_clear_n_i || count_value_o == $past(preset_inputs_i)) else $error("load wrong");
    a_count_step: assert property (run && !$past(sw_ld) && both |=>
        !async_clear_n_i || count_value_o == $past(count_value_o) + 4'h1) else $error("no step");
    a_hold_value: assert property (run && !$past(sw_ld) && !both |=>
        !async_clear_n_i || $stable(count_value_o)) else $error("hold broken");
    a_clear_release: assert property ($rose(async_clear_n_i) |-> count_value_o == 4'h0)
        else $error("value moved without edge");
    a_apb_ready: assert property (psel_i && penable_i |-> pready_o)
        else $error("no ready");
    a_slverr_map: assert property (psel_i && penable_i && paddr_i[1:0] == 2'b00 |->
        pslverr_o == (paddr_i > 8'h10)) else $error("slave error wrong");
endmodule // counter4_asserts
bind counter4_top counter4_asserts u_chk (.ref_clk_i, .rst_n_i, .async_clear_n_i,
    .load_enable_n_i, .count_enable_parallel_i, .count_enable_trickle_i, .preset_inputs_i,
    .count_value_o, .terminal_count_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .pslverr_o);
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, async_clear_n_i = 1'b1, load_enable_n_i = 1'b1;
    logic count_enable_parallel_i = 1'b0, count_enable_trickle_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, terminal_count_o, pready_o;
    logic pslverr_o, err;
    logic [3:0] preset_inputs_i = 4'h0, count_value_o, upper;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    int n_mismatch = 0, n_tests = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    counter4_top DUT (.ref_clk_i, .rst_n_i, .async_clear_n_i, .load_enable_n_i,
        .count_enable_parallel_i, .count_enable_trickle_i, .preset_inputs_i, .count_value_o,
        .terminal_count_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o);
    cascade_stage u_next (.ref_clk_i, .rst_n_i, .carry_i(terminal_count_o), .upper_o(upper));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    // inputs go out at one edge; the check after it sees the previous call's effect
    task cyc(input logic ld_n, input logic ep, input logic et, input logic [3:0] p);
        @(posedge ref_clk_i);
        load_enable_n_i <= ld_n;
        count_enable_parallel_i <= ep;
        count_enable_trickle_i <= et;
        preset_inputs_i <= p;
        @(negedge ref_clk_i);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task end_of_test;
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #5000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        cyc(1'b0, 1'b1, 1'b1, 4'hd);
        cyc(1'b1, 1'b1, 1'b1, 4'h0);
        chk(count_value_o, 4'hd);
        cyc(1'b1, 1'b1, 1'b1, 4'h0);
        chk(count_value_o, 4'he);
        cyc(1'b1, 1'b0, 1'b1, 4'h0);
        chk(count_value_o, 4'hf);
        chk(terminal_count_o, 1'b1);
        cyc(1'b1, 1'b1, 1'b0, 4'h0);
        chk(count_value_o, 4'hf);
        chk(terminal_count_o, 1'b0);
        cyc(1'b1, 1'b1, 1'b1, 4'h0);
        chk(count_value_o, 4'hf);
        cyc(1'b1, 1'b0, 1'b0, 4'h0);
        chk(count_value_o, 4'h0);
        chk(upper, 4'h2);
        cyc(1'b0, 1'b0, 1'b0, 4'h5);
        cyc(1'b1, 1'b0, 1'b0, 4'h0);
        chk(count_value_o, 4'h5);
        @(posedge ref_clk_i);
        async_clear_n_i <= 1'b0;
        load_enable_n_i <= 1'b0;
        // nonzero preset so a load that beat the clear would show up
        preset_inputs_i <= 4'h7;
        @(negedge ref_clk_i);
        chk(count_value_o, 4'h0);
        @(posedge ref_clk_i);
        async_clear_n_i <= 1'b1;
        load_enable_n_i <= 1'b1;
        @(negedge ref_clk_i);
        chk(count_value_o, 4'h0);
        apb(1'b1, 8'h04, 32'h0000000a);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0000000a);
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h00, 32'h00000001);
        cyc(1'b1, 1'b0, 1'b0, 4'h0);
        cyc(1'b1, 1'b0, 1'b0, 4'h0);
        chk(count_value_o, 4'ha);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[3:0], 4'ha);
        chk(rd, 32'h0000006a);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b1, 8'h08, 32'h00000020);
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h00, 32'h00000002);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000004a);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0000000a);
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
